// ### hw/nisw_ctrl.sv
// Purpose: per-interrupt state, priority arbitration and wake logic
// Assumes: AHB-Lite slave, zero wait states, core acknowledges offers
// Notes: rules below are tagged at the logic that keeps them
//
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module nisw_ctrl
  import nisw_pkg::*;
#(
  parameter int num_irq = NISW_MAX_IRQ
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [NISW_MAX_IRQ-1:0] irq_req,
  input wire logic nmi_req,
  input wire nisw_core_t core,
  input wire nisw_instr_t instr,
  input wire logic ext_event,
  input wire logic dbg_req,
  output nisw_offer_t offer,
  output logic event_out,
  output logic core_sleep
);
  if (num_irq < 1 || num_irq > NISW_MAX_IRQ) begin : g_bad_count
    $error("num_irq outside the supported range");
  end
  // the word layout assumes one high word and full priority coverage
  if (NISW_MAX_IRQ <= 32 || NISW_MAX_IRQ > 64) begin : g_bad_words
    $error("line count does not fit two words");
  end
  if (NISW_PRIO_WORDS * NISW_PRIO_PER_WORD < NISW_MAX_IRQ) begin : g_bad_prio
    $error("priority words do not cover every line");
  end
  if (NISW_PRIO_PER_WORD * NISW_PRIO_W > 32) begin : g_bad_field
    $error("priority fields overflow a word");
  end
  if (NISW_NMI_NUM != 6'(NISW_MAX_IRQ)) begin : g_bad_nmi
    $error("non-maskable number must follow the last line");
  end

  localparam logic [NISW_MAX_IRQ-1:0] LINE_MASK =
    NISW_MAX_IRQ'((64'h1 << num_irq) - 64'h1);

  nisw_state_t s;
  nisw_state_t next_s;

  // group part of a priority; sub bits are shifted away
  function automatic logic [4:0] grp_of(input logic [3:0] p,
                                        input logic [2:0] sp);
    logic [2:0] sh;
    sh = (sp > 3'h4) ? 3'h4 : sp;
    grp_of = {1'b0, p >> sh};
  endfunction

  // a data-phase write that lands on one register
  function automatic logic wr_hit(input logic dwr, input logic [7:0] wa,
                                  input logic [7:0] a);
    wr_hit = dwr && (wa == a);
  endfunction

  // spread one written word over the low or high group of lines
  function automatic logic [NISW_MAX_IRQ-1:0] word_vec(
      input logic lo, input logic hi, input logic [31:0] w);
    word_vec = '0;
    if (lo) begin
      word_vec[31:0] = w;
    end else if (hi) begin
      word_vec[NISW_MAX_IRQ-1:32] = w[NISW_MAX_IRQ-33:0];
    end
  endfunction

  logic accept;
  logic [NISW_MAX_IRQ-1:0] rise;
  logic [NISW_MAX_IRQ-1:0] ena_set;
  logic [NISW_MAX_IRQ-1:0] ena_clr;
  logic [NISW_MAX_IRQ-1:0] pnd_set;
  logic [NISW_MAX_IRQ-1:0] pnd_clr;
  logic [NISW_MAX_IRQ-1:0] new_pend;
  logic [NISW_MAX_IRQ-1:0] cand;
  logic best_found;
  logic [5:0] best_num;
  logic [3:0] best_prio;
  logic [4:0] cur_grp;
  logic [4:0] limit;
  logic take_irq;
  logic wake;
  logic [7:0] wa;
  logic [7:0] ra;
  logic [3:0] bp_w;
  logic [31:0] rd;

  always_comb begin
    next_s = s;
    accept = hsel & htrans[1] & hready;
    wa = s.daddr;
    next_s.sev_out = instr.send_event_instr;
    next_s.dwr = accept & hwrite;
    next_s.daddr = {haddr[7:2], 2'b00};

    // software writes in the data phase
    ena_set = word_vec(s.dwr && wa == NISW_ENA_SET_LO,
                       s.dwr && wa == NISW_ENA_SET_HI, hwdata);
    ena_clr = word_vec(s.dwr && wa == NISW_ENA_CLR_LO,
                       s.dwr && wa == NISW_ENA_CLR_HI, hwdata);
    pnd_set = word_vec(s.dwr && wa == NISW_PND_SET_LO,
                       s.dwr && wa == NISW_PND_SET_HI, hwdata);
    pnd_clr = word_vec(s.dwr && wa == NISW_PND_CLR_LO,
                       s.dwr && wa == NISW_PND_CLR_HI, hwdata);
    // an out-of-range number on the trigger register is dropped
    if (wr_hit(s.dwr, wa, NISW_SW_TRIG) && hwdata < 32'(num_irq)) begin
      pnd_set[hwdata[5:0]] = 1'b1;
    end
    next_s.enable = (s.enable | ena_set) & ~ena_clr & LINE_MASK;
    for (int k = 0; k < NISW_PRIO_WORDS; k++) begin
      if (wr_hit(s.dwr, wa, NISW_PRIO0 + 8'(4 * k))) begin
        for (int j = 0; j < NISW_PRIO_PER_WORD; j++) begin
          if (k * NISW_PRIO_PER_WORD + j < NISW_MAX_IRQ) begin
            next_s.prio[k * NISW_PRIO_PER_WORD + j] =
              hwdata[4 * j +: NISW_PRIO_W];
          end
        end
      end
    end
    bp_w = hwdata[NISW_PRIO_W-1:0];
    if (wr_hit(s.dwr, wa, NISW_BASE_PRI)) begin
      next_s.base_pri = bp_w;
    end
    if (wr_hit(s.dwr, wa, NISW_COND_RAISE) && bp_w != 4'h0 &&
        (s.base_pri == 4'h0 || bp_w < s.base_pri)) begin
      next_s.base_pri = bp_w;
    end
    if (wr_hit(s.dwr, wa, NISW_CTRL)) begin
      next_s.split = hwdata[NISW_CTRL_SPLIT_LSB +: NISW_SPLIT_W];
      next_s.wake_on_pend = hwdata[NISW_CTRL_WOP_BIT];
      next_s.dbg_en = hwdata[NISW_CTRL_DBG_BIT];
    end

    // core entry and return move the active state first
    if (core.enter && core.num == NISW_NMI_NUM && s.nmi_pend) begin
      next_s.nmi_act = 1'b1;
    end
    if (core.ret && core.num == NISW_NMI_NUM) begin
      next_s.nmi_act = 1'b0;
    end
    if (core.enter && core.num < 6'(num_irq) && s.pending[core.num]) begin
      next_s.active[core.num] = 1'b1;
    end
    if (core.ret && core.num < 6'(num_irq)) begin
      next_s.active[core.num] = 1'b0;
    end

    // hardware sources; a set in the same cycle beats any clear
    next_s.req_q = irq_req & LINE_MASK;
    rise = irq_req & ~s.req_q & LINE_MASK;
    new_pend = ((irq_req & ~next_s.active) | rise) & LINE_MASK;
    next_s.pending = s.pending & ~(pnd_clr & ~irq_req);
    if (core.enter && core.num < 6'(num_irq)) begin
      next_s.pending[core.num] = 1'b0;
    end
    next_s.pending = next_s.pending | new_pend | (pnd_set & LINE_MASK);
    next_s.nmi_q = nmi_req;
    if (core.enter && core.num == NISW_NMI_NUM) begin
      next_s.nmi_pend = 1'b0;
    end
    if (nmi_req && !s.nmi_q) begin
      next_s.nmi_pend = 1'b1;
    end

    // arbitration on the updated state
    cand = next_s.pending & next_s.enable & ~next_s.active;
    best_found = 1'b0;
    best_num = '0;
    best_prio = '0;
    for (int i = 0; i < NISW_MAX_IRQ; i++) begin
      if (cand[i] && (!best_found || next_s.prio[i] < best_prio)) begin
        best_found = 1'b1;
        best_num = 6'(i);
        best_prio = next_s.prio[i];
      end
    end
    cur_grp = NISW_THREAD_GRP;
    for (int i = 0; i < NISW_MAX_IRQ; i++) begin
      if (next_s.active[i] && grp_of(next_s.prio[i], next_s.split) < cur_grp)
      begin
        cur_grp = grp_of(next_s.prio[i], next_s.split);
      end
    end
    limit = (next_s.base_pri == 4'h0) ? NISW_THREAD_GRP :
            grp_of(next_s.base_pri, next_s.split);
    if (limit < cur_grp) begin
      cur_grp = limit;
    end
    // an active non-maskable handler blocks every peripheral line
    take_irq = best_found && !next_s.nmi_act &&
               grp_of(best_prio, next_s.split) < cur_grp;
    next_s.offer.valid = 1'b0;
    next_s.offer.num = '0;
    if (next_s.nmi_pend && !next_s.nmi_act) begin
      next_s.offer.valid = 1'b1;
      next_s.offer.num = NISW_NMI_NUM;
    end else if (take_irq) begin
      next_s.offer.valid = 1'b1;
      next_s.offer.num = best_num;
    end

    // event register and sleep; an outside event also sets the register,
    // so a later wait-event returns at once
    if (instr.wait_event_instr && s.evt_reg) begin
      next_s.evt_reg = 1'b0;
    end
    if (instr.send_event_instr || ext_event) begin
      next_s.evt_reg = 1'b1;
    end
    wake = 1'b0;
    unique case (s.pwr)
      NISW_RUN: begin
        if (instr.wait_event_instr && !s.evt_reg) begin
          next_s.pwr = NISW_WFE_SLEEP;
        end else if (instr.wait_interrupt_instr) begin
          next_s.pwr = NISW_WFI_SLEEP;
        end
      end
      NISW_WFE_SLEEP: begin
        wake = next_s.offer.valid || ext_event ||
               (s.wake_on_pend && (|(next_s.pending & ~s.pending) ||
                                   (next_s.nmi_pend && !s.nmi_pend))) ||
               (dbg_req && s.dbg_en);
        if (wake) begin
          next_s.pwr = NISW_RUN;
        end
      end
      NISW_WFI_SLEEP: begin
        wake = next_s.offer.valid || dbg_req;
        if (wake) begin
          next_s.pwr = NISW_RUN;
        end
      end
      default: begin
        next_s.pwr = NISW_RUN;
      end
    endcase

    // read data is taken from the updated state so a write is seen at once
    ra = {haddr[7:2], 2'b00};
    rd = '0;
    unique case (ra)
      NISW_ENA_SET_LO, NISW_ENA_CLR_LO: begin
        rd = next_s.enable[31:0];
      end
      NISW_ENA_SET_HI, NISW_ENA_CLR_HI: begin
        rd = 32'(next_s.enable[34:32]);
      end
      NISW_PND_SET_LO, NISW_PND_CLR_LO: begin
        rd = next_s.pending[31:0];
      end
      NISW_PND_SET_HI, NISW_PND_CLR_HI: begin
        rd = 32'(next_s.pending[34:32]);
      end
      NISW_ACT_LO: begin
        rd = next_s.active[31:0];
      end
      NISW_ACT_HI: begin
        rd = 32'(next_s.active[34:32]);
      end
      NISW_BASE_PRI, NISW_COND_RAISE: begin
        rd = 32'(next_s.base_pri);
      end
      NISW_CTRL: begin
        rd[NISW_CTRL_SPLIT_LSB +: NISW_SPLIT_W] = next_s.split;
        rd[NISW_CTRL_WOP_BIT] = next_s.wake_on_pend;
        rd[NISW_CTRL_DBG_BIT] = next_s.dbg_en;
      end
      NISW_STATUS: begin
        rd[NISW_ST_EVT_BIT] = next_s.evt_reg;
        rd[NISW_ST_SLEEP_LSB +: 2] = next_s.pwr;
        rd[NISW_ST_NMI_ACT_BIT] = next_s.nmi_act;
        rd[NISW_ST_OFFER_VLD_BIT] = next_s.offer.valid;
        rd[NISW_ST_OFFER_LSB +: 6] = next_s.offer.num;
      end
      default: begin
        for (int k = 0; k < NISW_PRIO_WORDS; k++) begin
          if (ra == NISW_PRIO0 + 8'(4 * k)) begin
            for (int j = 0; j < NISW_PRIO_PER_WORD; j++) begin
              if (k * NISW_PRIO_PER_WORD + j < NISW_MAX_IRQ) begin
                rd[4 * j +: NISW_PRIO_W] =
                  next_s.prio[k * NISW_PRIO_PER_WORD + j];
              end
            end
          end
        end
      end
    endcase
    // the trigger register is write-only and reads as zero
    next_s.hrdata = (accept && !hwrite) ? rd : 32'h0000_0000;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.hrdata;
  // offer is registered, so the core sees it one edge after its cause
  assign offer = s.offer;
  assign event_out = s.sev_out;
  // sleep decodes the power state flops only, so it cannot glitch
  assign core_sleep = (s.pwr != NISW_RUN);
endmodule
`default_nettype wire

// ### hw/nisw_pkg.sv
// Purpose: shared constants and carriers of the interrupt state and wake block
// Assumes: one clock, AHB-Lite register access, 32-bit words
// Notes: register offsets are byte addresses within the block window
package nisw_pkg;
  localparam int NISW_MAX_IRQ = 35;
  localparam int NISW_PRIO_W = 4;
  localparam int NISW_SPLIT_W = 3;
  localparam int NISW_PRIO_PER_WORD = 8;
  localparam int NISW_PRIO_WORDS = 5;
  localparam logic [5:0] NISW_NMI_NUM = 6'h23;
  localparam logic [4:0] NISW_THREAD_GRP = 5'h10;
  localparam logic [3:0] NISW_PRIO_RESET = 4'h0;
  // register offsets
  localparam logic [7:0] NISW_ENA_SET_LO = 8'h00;
  localparam logic [7:0] NISW_ENA_SET_HI = 8'h04;
  localparam logic [7:0] NISW_ENA_CLR_LO = 8'h08;
  localparam logic [7:0] NISW_ENA_CLR_HI = 8'h0c;
  localparam logic [7:0] NISW_PND_SET_LO = 8'h10;
  localparam logic [7:0] NISW_PND_SET_HI = 8'h14;
  localparam logic [7:0] NISW_PND_CLR_LO = 8'h18;
  localparam logic [7:0] NISW_PND_CLR_HI = 8'h1c;
  localparam logic [7:0] NISW_ACT_LO = 8'h20;
  localparam logic [7:0] NISW_ACT_HI = 8'h24;
  localparam logic [7:0] NISW_PRIO0 = 8'h28;
  localparam logic [7:0] NISW_SW_TRIG = 8'h40;
  localparam logic [7:0] NISW_BASE_PRI = 8'h44;
  localparam logic [7:0] NISW_COND_RAISE = 8'h48;
  localparam logic [7:0] NISW_CTRL = 8'h4c;
  localparam logic [7:0] NISW_STATUS = 8'h50;
  // control and status fields
  localparam int NISW_CTRL_SPLIT_LSB = 0;
  localparam int NISW_CTRL_WOP_BIT = 3;
  localparam int NISW_CTRL_DBG_BIT = 4;
  localparam int NISW_ST_EVT_BIT = 0;
  localparam int NISW_ST_SLEEP_LSB = 1;
  localparam int NISW_ST_NMI_ACT_BIT = 3;
  localparam int NISW_ST_OFFER_VLD_BIT = 4;
  localparam int NISW_ST_OFFER_LSB = 8;

  typedef enum logic [1:0] {
    NISW_RUN = 2'b00,
    NISW_WFE_SLEEP = 2'b01,
    NISW_WFI_SLEEP = 2'b10
  } nisw_pwr_t;

  typedef struct packed {
    logic valid;
    logic [5:0] num;
  } nisw_offer_t;

  typedef struct packed {
    logic enter;
    logic ret;
    logic [5:0] num;
  } nisw_core_t;

  typedef struct packed {
    logic send_event_instr;
    logic wait_event_instr;
    logic wait_interrupt_instr;
  } nisw_instr_t;

  typedef struct packed {
    logic [NISW_MAX_IRQ-1:0] enable;
    logic [NISW_MAX_IRQ-1:0] pending;
    logic [NISW_MAX_IRQ-1:0] active;
    logic [NISW_MAX_IRQ-1:0] req_q;
    logic [NISW_MAX_IRQ-1:0][NISW_PRIO_W-1:0] prio;
    logic nmi_pend;
    logic nmi_act;
    logic nmi_q;
    logic [NISW_PRIO_W-1:0] base_pri;
    logic [NISW_SPLIT_W-1:0] split;
    logic wake_on_pend;
    logic dbg_en;
    logic evt_reg;
    nisw_pwr_t pwr;
    logic sev_out;
    nisw_offer_t offer;
    logic dwr;
    logic [7:0] daddr;
    logic [31:0] hrdata;
  } nisw_state_t;
endpackage

// ### testbench/nisw_core_model.sv
// Purpose: core-side partner that takes offers and returns on command
// Assumes: one nesting level, enters only the offered number
// Notes: take_en holds entry off so a slow core can be modelled
`timescale 1ns/1ps
`default_nettype none
module nisw_core_model
  import nisw_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire nisw_offer_t offer,
  input wire logic take_en,
  input wire logic ret_go,
  output nisw_core_t core
);
  logic [5:0] act_num;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core <= '0;
      act_num <= 6'h0;
    end else begin
      core.enter <= 1'b0;
      core.ret <= 1'b0;
      // offer is still stale in the enter cycle, so skip it once
      if (offer.valid && take_en && !core.enter) begin
        core.enter <= 1'b1;
        core.num <= offer.num;
        act_num <= offer.num;
      end else if (ret_go) begin
        core.ret <= 1'b1;
        core.num <= act_num;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/nisw_ctrl_chk.sv
// Purpose: port assertions for the interrupt state and wake block
// Assumes: one clock; helpers follow inputs only
// Notes: event helper ignores ext_event, so it never claims a set too many
`timescale 1ns/1ps
`default_nettype none
module nisw_ctrl_chk
  import nisw_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire nisw_core_t core,
  input wire nisw_instr_t instr,
  input wire logic ext_event,
  input wire logic dbg_req,
  input wire logic nmi_req,
  input wire nisw_offer_t offer,
  input wire logic event_out,
  input wire logic core_sleep
);
  logic evt_h;
  logic wfi_h;
  logic nmi_h;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_h <= 1'b0;
      wfi_h <= 1'b0;
      nmi_h <= 1'b0;
    end else begin
      evt_h <= instr.send_event_instr | (evt_h & ~instr.wait_event_instr);
      wfi_h <= instr.wait_interrupt_instr | (wfi_h & ~instr.wait_event_instr);
      if (core.num == NISW_NMI_NUM) begin
        nmi_h <= core.enter | (nmi_h & ~core.ret);
      end
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_take;
    core.enter && offer.valid && core.num == offer.num;
  endsequence
  sequence s_nmi_offer;
    offer.valid && offer.num == NISW_NMI_NUM;
  endsequence
  property p_sev; instr.send_event_instr |=> event_out; endproperty
  a_sev: assert property (p_sev) else $error("no event pulse");
  property p_stray; !instr.send_event_instr |=> !event_out; endproperty
  a_stray: assert property (p_stray) else $error("stray event");
  property p_skip;
    instr.wait_event_instr && evt_h && !instr.send_event_instr && !core_sleep |=> !core_sleep;
  endproperty
  a_skip: assert property (p_skip) else $error("wfe slept");
  property p_ext; !wfi_h && core_sleep && ext_event |=> !core_sleep;
  endproperty
  a_ext: assert property (p_ext) else $error("no ext wake");
  property p_dbg; wfi_h && core_sleep && dbg_req |=> !core_sleep;
  endproperty
  a_dbg: assert property (p_dbg) else $error("no dbg wake");
  property p_irq; wfi_h && core_sleep && offer.valid |=> !core_sleep;
  endproperty
  a_irq: assert property (p_irq) else $error("no irq wake");
  property p_enter;
    s_take |=> !(offer.valid && offer.num == $past(core.num));
  endproperty
  a_enter: assert property (p_enter) else $error("reoffered");
  property p_nmi; $rose(nmi_req) && !nmi_h |-> ##[1:2] s_nmi_offer;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi not offered");
endmodule
bind nisw_ctrl nisw_ctrl_chk nisw_ctrl_chk_inst (.*);
`default_nettype wire

// ### testbench/nisw_ctrl_tb_top.sv
// Purpose: self-checking bench for the interrupt state and wake block
// Assumes: one bus slave, hready tied to hreadyout, 200 MHz clock
// Notes: register rows first, then pending, trigger, nmi and sleep cases
`timescale 1ns/1ps
`default_nettype none
module nisw_ctrl_tb_top
  import nisw_pkg::*;
;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
  } nisw_row_t;
  localparam nisw_instr_t sev_i = 3'h4;
  localparam nisw_instr_t wfe_i = 3'h2;
  localparam nisw_instr_t wfi_i = 3'h1;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hready, hreadyout, hresp, event_out, core_sleep;
  logic nmi_req = 1'b0, ext_event = 1'b0, dbg_req = 1'b0;
  logic take_en = 1'b0, ret_go = 1'b0;
  logic [NISW_MAX_IRQ-1:0] irq_req = '0;
  nisw_core_t core;
  nisw_instr_t instr = '0;
  nisw_offer_t offer;
  int err_count = 0, samples_checked = 0;
  nisw_row_t rows [11] = '{
    '{NISW_ENA_SET_LO, 32'hffffffff, 32'hffffffff},
    '{NISW_ENA_SET_HI, 32'hffffffff, 32'h00000007},
    '{NISW_PRIO0, 32'h76543210, 32'h76543210},
    '{NISW_CTRL, 32'h00000008, 32'h00000008},
    '{NISW_COND_RAISE, 32'h00000009, 32'h00000009},
    '{NISW_COND_RAISE, 32'h00000003, 32'h00000003},
    '{NISW_COND_RAISE, 32'h00000007, 32'h00000003},
    '{NISW_COND_RAISE, 32'h00000000, 32'h00000003},
    '{NISW_BASE_PRI, 32'h00000000, 32'h00000000},
    '{NISW_ACT_LO, 32'h0000ffff, 32'h00000000},
    '{8'h80, 32'h00001234, 32'h00000000}};
  assign hready = hreadyout;
  always #2.5 hclk = ~hclk;
  nisw_ctrl #(.num_irq(NISW_MAX_IRQ)) nisw_ctrl_inst (.*);
  nisw_core_model nisw_core_model_inst (.*);
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic fail(input logic [31:0] got, input logic [31:0] exp);
    err_count++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) fail(got, exp);
  endtask
  task automatic chko(input nisw_offer_t exp);
    samples_checked++;
    if (offer !== exp) fail({25'h0, offer}, {25'h0, exp});
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    chk(rd, e);
  endtask
  task automatic ins(input nisw_instr_t v);
    instr <= v;
    tick(1);
    instr <= '0;
    tick(1);
  endtask
  task automatic wake(input logic e, input logic d);
    ext_event <= e;
    dbg_req <= d;
    tick(1);
    ext_event <= 1'b0;
    dbg_req <= 1'b0;
    tick(1);
  endtask
  task automatic take_ret(input logic take);
    take_en <= take;
    tick(3);
    take_en <= 1'b0;
    ret_go <= 1'b1;
    tick(1);
    ret_go <= 1'b0;
    tick(3);
  endtask
  task automatic summarize();
    $display("checked=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    tick(20000);
    err_count++;
    summarize();
  end
  initial begin
    tick(16);
    hresetn <= 1'b1;
    tick(1);
    chko('0);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    rdc(NISW_PND_CLR_LO, 32'h0);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].addr, rows[i].wdata);
      rdc(rows[i].addr, rows[i].rdata);
    end
    $display("register rows done");
    bus(1'b1, NISW_ENA_CLR_LO, 32'h8);
    irq_req[3] <= 1'b1;
    tick(2);
    rdc(NISW_PND_CLR_LO, 32'h8);
    chko('0);
    bus(1'b1, NISW_PND_CLR_LO, 32'h8);
    rdc(NISW_PND_CLR_LO, 32'h8);
    bus(1'b1, NISW_ENA_SET_LO, 32'h8);
    tick(2);
    chko('{1'b1, 6'h3});
    take_en <= 1'b1;
    tick(3);
    take_en <= 1'b0;
    rdc(NISW_ACT_LO, 32'h8);
    rdc(NISW_PND_CLR_LO, 32'h0);
    take_ret(1'b0);
    rdc(NISW_PND_CLR_LO, 32'h8);
    irq_req[3] <= 1'b0;
    take_ret(1'b1);
    rdc(NISW_ACT_LO, 32'h0);
    rdc(NISW_PND_CLR_LO, 32'h0);
    $display("level line done");
    irq_req[5] <= 1'b1;
    tick(1);
    irq_req[5] <= 1'b0;
    tick(2);
    rdc(NISW_PND_CLR_LO, 32'h20);
    bus(1'b1, NISW_PND_CLR_LO, 32'h20);
    bus(1'b1, NISW_PND_SET_LO, 32'h40);
    bus(1'b1, NISW_SW_TRIG, 32'h21);
    bus(1'b1, NISW_SW_TRIG, 32'h23);
    rdc(NISW_PND_CLR_LO, 32'h40);
    rdc(NISW_PND_CLR_HI, 32'h2);
    chko('{1'b1, 6'h21});
    bus(1'b1, NISW_PRIO0 + 8'h10, 32'hf0);
    tick(2);
    chko('{1'b1, 6'h6});
    bus(1'b1, NISW_PND_CLR_LO, 32'h40);
    bus(1'b1, NISW_PND_CLR_HI, 32'h2);
    bus(1'b1, NISW_BASE_PRI, 32'h1);
    nmi_req <= 1'b1;
    tick(3);
    chko('{1'b1, NISW_NMI_NUM});
    take_ret(1'b1);
    nmi_req <= 1'b0;
    $display("edge, trigger and nmi done");
    ins(sev_i);
    chk({31'h0, event_out}, 32'h1);
    ins(wfe_i);
    chk({31'h0, core_sleep}, 32'h0);
    ins(wfe_i);
    chk({31'h0, core_sleep}, 32'h1);
    wake(1'b0, 1'b1);
    chk({31'h0, core_sleep}, 32'h1);
    wake(1'b1, 1'b0);
    chk({31'h0, core_sleep}, 32'h0);
    ins(wfe_i);
    ins(wfe_i);
    chk({31'h0, core_sleep}, 32'h1);
    bus(1'b1, NISW_PND_SET_LO, 32'h40);
    tick(3);
    chk({31'h0, core_sleep}, 32'h0);
    bus(1'b1, NISW_PND_CLR_LO, 32'h40);
    ins(wfi_i);
    chk({31'h0, core_sleep}, 32'h1);
    wake(1'b0, 1'b1);
    chk({31'h0, core_sleep}, 32'h0);
    ins(wfi_i);
    chk({31'h0, core_sleep}, 32'h1);
    bus(1'b1, NISW_PND_SET_LO, 32'h1);
    tick(3);
    chk({31'h0, core_sleep}, 32'h0);
    bus(1'b1, NISW_PND_CLR_LO, 32'h1);
    $display("sleep and events done");
    summarize();
  end
endmodule
`default_nettype wire
